// ===== hw/dhr_cfg.svh
`ifndef DHR_CFG_SVH
`define DHR_CFG_SVH
// Notes on behaviour
// - feature code picks the subcommand: data, thresholds, autosave, enable, disable, status
// - unknown feature codes end in a command abort
// - D8h enables, D9h disables; the state is written to non-volatile storage
// - autosave completes and changes nothing
// - read data returns one 512-byte sector starting with version 0004h
// - bytes 2..361 hold thirty 12-byte slots, six filled
// - off-line, self-test and error logging bytes read zero
// - bytes 386..387 carry vendor content version 0002h
// - byte 396 is 1 once global wear leveling started, else 0
// - byte 397 is 1 once spares are borrowed across chips, else 0
// - spare attribute c4h, flags 0003h, value is minimum spare percentage
// - spare raw: chosen chip initial, current, then sums of both
// - status flags exceeded when spare value is below its threshold
// - erase attribute E5h, flags 0002h, life percent, raw total erases
// - status flags exceeded when erase value is below its threshold
// - total ecc attribute CBh, value 64h, raw counts all errors
// - correctable ecc attribute CCh, value 64h, raw counts corrected errors
// - ecc attributes take no part in status evaluation
// - status loads F4h/2Ch when exceeded, else 4Fh/C2h
// - read thresholds returns one sector, zero thresholds for counters
// - read count attribute E8h, value 64h, raw total flash reads
// - crc error attribute C7h, value 64h, raw udma crc errors

// register byte addresses
`define DHR_OFS_FEATURE   12'h000
`define DHR_OFS_CYL_LO    12'h004
`define DHR_OFS_CYL_HI    12'h008
`define DHR_OFS_COMMAND   12'h00C
`define DHR_OFS_STATUS    12'h010
`define DHR_OFS_DATA      12'h014
`define DHR_OFS_THRESH    12'h018
// status bit positions
`define DHR_ST_BUSY       0
`define DHR_ST_DRQ        1
`define DHR_ST_ABORT      2
`define DHR_ST_ENABLED    3
`define DHR_ST_EXCEEDED   4
// command and features
`define DHR_CMD_HEALTH    8'hB0
`define DHR_FEA_READ      8'hD0
`define DHR_FEA_THRESH    8'hD1
`define DHR_FEA_AUTOSAVE  8'hD2
`define DHR_FEA_ENABLE    8'hD8
`define DHR_FEA_DISABLE   8'hD9
`define DHR_FEA_STATUS    8'hDA
// signatures
`define DHR_SIG_LO_OK     8'h4F
`define DHR_SIG_HI_OK     8'hC2
`define DHR_SIG_LO_BAD    8'hF4
`define DHR_SIG_HI_BAD    8'h2C
// sector layout
`define DHR_STRUCT_VER    16'h0004
`define DHR_VENDOR_VER    16'h0002
`define DHR_CAPS          16'h0003
`define DHR_SLOT_FIRST    9'd2
`define DHR_SLOT_END      9'd74
`define DHR_SLOT_BYTES    9'd12
`define DHR_OFS_CAPS      9'd368
`define DHR_OFS_VVER      9'd386
`define DHR_OFS_COMMIT    9'd388
`define DHR_OFS_WLTH      9'd392
`define DHR_OFS_WEAR      9'd396
`define DHR_OFS_GBB       9'd397
`define DHR_LAST_BYTE     9'd511
// attributes
`define DHR_ID_SPARE      8'hC4
`define DHR_ID_ERASE      8'hE5
`define DHR_ID_ECC_ALL    8'hCB
`define DHR_ID_ECC_COR    8'hCC
`define DHR_ID_READS      8'hE8
`define DHR_ID_CRC        8'hC7
`define DHR_FLAGS_PREFAIL 16'h0003
`define DHR_FLAGS_ADVIS   16'h0002
`define DHR_FIXED_VALUE   8'h64
`define DHR_PERCENT       32'd100
`define DHR_WEAR_THRESH   32'd100000
`define DHR_THRESH_RESET  16'h0000
`endif

// ===== hw/dhr_pkg.sv
package dhr_pkg;
  // transfer state of the sector stream
  typedef enum logic [0:0] {
    DHR_IDLE = 1'b0,
    DHR_XFER = 1'b1
  } dhr_state_type;
endpackage

// ===== hw/dhr_engine.sv
`include "dhr_cfg.svh"

module dhr_engine #(
  parameter int NCHIP = 2
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // health figures from the flash manager
  input  wire logic [NCHIP*16-1:0] spare_init,
  input  wire logic [NCHIP*16-1:0] spare_cur,
  input  wire logic [7:0]        life_pct,
  input  wire logic [63:0]       erase_total,
  input  wire logic [31:0]       ecc_all,
  input  wire logic [31:0]       ecc_cor,
  input  wire logic [63:0]       read_total,
  input  wire logic [31:0]       crc_errors,
  input  wire logic [31:0]       commit_cnt,
  input  wire logic [31:0]       chip_erase_max,
  input  wire logic              spare_borrowed,
  // non-volatile enable storage
  input  wire logic              nv_enabled,
  output logic                   nv_write,
  output logic                   nv_value
);
  // all checks run on the system clock and rest while reset is held
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ************************************************************
  // helpers
  // ************************************************************
  // byte n of a little-endian word
  function automatic logic [7:0] le_byte(input logic [63:0] w, input logic [3:0] n);
    le_byte = w[{n[2:0], 3'b000} +: 8];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]                feature_reg, feature_next;
  logic [7:0]                cyl_lo_reg, cyl_lo_next;
  logic [7:0]                cyl_hi_reg, cyl_hi_next;
  logic [15:0]               thresh_reg, thresh_next;
  logic                      en_reg, en_next;
  logic                      loaded_reg, loaded_next;
  logic                      abort_reg, abort_next;
  logic                      exceed_reg, exceed_next;
  logic                      thr_mode_reg, thr_mode_next;
  logic [8:0]                idx_reg, idx_next;
  logic [7:0]                sum_reg, sum_next;
  logic                      nvw_reg, nvw_next;
  dhr_pkg::dhr_state_type    state_reg, state_next;
  logic [31:0]               prdata_reg, prdata_next;
  logic                      pready_reg, pready_next;
  logic                      pslverr_reg, pslverr_next;

  // ************************************************************
  // spare block summary
  // ************************************************************
  logic [7:0]  sp_val;
  logic [15:0] sp_ch_init, sp_ch_cur;
  logic [15:0] sp_sum_init, sp_sum_cur;
  logic        exceeded;

  // minimum percentage over chips, sums over all chips
  always_comb begin
    logic [31:0] pct;
    logic [31:0] best;
    pct         = 32'h0000_0000;
    best        = `DHR_PERCENT;
    sp_ch_init  = spare_init[15:0];
    sp_ch_cur   = spare_cur[15:0];
    sp_sum_init = 16'h0000;
    sp_sum_cur  = 16'h0000;
    for (int i = 0; i < NCHIP; i++) begin
      // a chip with no spares at all counts as full to avoid dividing by zero
      if (spare_init[i*16 +: 16] == 16'h0000) begin
        pct = `DHR_PERCENT;
      end else begin
        pct = ({16'h0000, spare_cur[i*16 +: 16]} * `DHR_PERCENT)
              / {16'h0000, spare_init[i*16 +: 16]};
      end
      if (pct < best) begin
        best       = pct;
        sp_ch_init = spare_init[i*16 +: 16];
        sp_ch_cur  = spare_cur[i*16 +: 16];
      end
      sp_sum_init = sp_sum_init + spare_init[i*16 +: 16];
      sp_sum_cur  = sp_sum_cur + spare_cur[i*16 +: 16];
    end
    sp_val = best[7:0];
  end

  // only spare and erase attributes count, the ecc ones never do
  assign exceeded = (sp_val < thresh_reg[7:0])
                    || (life_pct < thresh_reg[15:8]);
  // ************************************************************
  // sector byte generator
  // ************************************************************
  logic [7:0] cur_byte;
  // byte at idx_reg of the data or threshold sector; counters are read live
  always_comb begin
    logic [8:0] rel;
    logic [3:0] slot;
    logic [3:0] ofs;
    logic [63:0] raw;
    logic [7:0]  id;
    logic [15:0] flg;
    logic [7:0]  val;
    logic [7:0]  th;
    rel  = idx_reg - `DHR_SLOT_FIRST;
    slot = 4'(rel / `DHR_SLOT_BYTES);
    ofs  = 4'(rel % `DHR_SLOT_BYTES);
    raw  = 64'h0000_0000_0000_0000;
    id   = 8'h00;
    flg  = `DHR_FLAGS_ADVIS;
    val  = `DHR_FIXED_VALUE;
    th   = 8'h00;
    case (slot)
      4'd0: begin
        id  = `DHR_ID_SPARE;
        flg = `DHR_FLAGS_PREFAIL;
        val = sp_val;
        raw = {sp_sum_cur, sp_sum_init, sp_ch_cur, sp_ch_init};
        th  = thresh_reg[7:0];
      end
      4'd1: begin
        id  = `DHR_ID_ERASE;
        val = life_pct;
        raw = erase_total;
        th  = thresh_reg[15:8];
      end
      4'd2: begin
        id  = `DHR_ID_ECC_ALL;
        raw = {32'h0000_0000, ecc_all};
      end
      4'd3: begin
        id  = `DHR_ID_ECC_COR;
        raw = {32'h0000_0000, ecc_cor};
      end
      4'd4: begin
        id  = `DHR_ID_READS;
        raw = read_total;
      end
      4'd5: begin
        id  = `DHR_ID_CRC;
        raw = {32'h0000_0000, crc_errors};
      end
      default: flg = 16'h0000;  // slots past the sixth never reach the stream
    endcase
    cur_byte = 8'h00;  // reserved, off-line, self-test and logging bytes
    if (idx_reg == `DHR_LAST_BYTE) begin
      cur_byte = 8'(-sum_reg);
    end else if (idx_reg < `DHR_SLOT_FIRST) begin
      cur_byte = le_byte({48'h0, `DHR_STRUCT_VER}, 4'(idx_reg));
    end else if (idx_reg < `DHR_SLOT_END) begin
      if (ofs == 4'd0) begin
        cur_byte = id;
      end else if (thr_mode_reg) begin
        cur_byte = (ofs == 4'd1) ? th : 8'h00;
      end else if (ofs < 4'd3) begin
        cur_byte = le_byte({48'h0, flg}, 4'(ofs - 4'd1));
      end else if (ofs == 4'd3) begin
        cur_byte = val;
      end else begin
        cur_byte = le_byte(raw, 4'(ofs - 4'd4));
      end
    end else if (!thr_mode_reg) begin
      if (idx_reg == `DHR_OFS_CAPS || idx_reg == `DHR_OFS_CAPS + 9'd1) begin
        cur_byte = le_byte({48'h0, `DHR_CAPS}, 4'(idx_reg - `DHR_OFS_CAPS));
      end else if (idx_reg == `DHR_OFS_VVER || idx_reg == `DHR_OFS_VVER + 9'd1) begin
        cur_byte = le_byte({48'h0, `DHR_VENDOR_VER}, 4'(idx_reg - `DHR_OFS_VVER));
      end else if (idx_reg >= `DHR_OFS_COMMIT && idx_reg < `DHR_OFS_WLTH) begin
        cur_byte = le_byte({32'h0, commit_cnt}, 4'(idx_reg - `DHR_OFS_COMMIT));
      end else if (idx_reg >= `DHR_OFS_WLTH && idx_reg < `DHR_OFS_WEAR) begin
        cur_byte = le_byte({32'h0, `DHR_WEAR_THRESH}, 4'(idx_reg - `DHR_OFS_WLTH));
      end else if (idx_reg == `DHR_OFS_WEAR) begin
        cur_byte = {7'h00, chip_erase_max >= `DHR_WEAR_THRESH};
      end else if (idx_reg == `DHR_OFS_GBB) begin
        cur_byte = {7'h00, spare_borrowed};
      end
    end
  end

  // ************************************************************
  // apb decode and command engine
  // ************************************************************
  logic acc_go, wr_go, rd_go, cmd_fire, data_pop;
  // a transfer takes effect on the first access cycle, answered one edge later
  assign acc_go   = psel && penable && !pready_reg;
  assign wr_go    = acc_go && pwrite;
  assign rd_go    = acc_go && !pwrite;
  assign cmd_fire = wr_go && paddr == `DHR_OFS_COMMAND && pwdata[7:0] == `DHR_CMD_HEALTH;
  assign data_pop = rd_go && paddr == `DHR_OFS_DATA && state_reg == dhr_pkg::DHR_XFER;
  // next state of registers, bus answer and sector stream
  always_comb begin
    feature_next  = feature_reg;
    cyl_lo_next   = cyl_lo_reg;
    cyl_hi_next   = cyl_hi_reg;
    thresh_next   = thresh_reg;
    en_next       = en_reg;
    loaded_next   = 1'b1;
    abort_next    = abort_reg;
    exceed_next   = exceed_reg;
    thr_mode_next = thr_mode_reg;
    idx_next      = idx_reg;
    sum_next      = sum_reg;
    nvw_next      = 1'b0;
    state_next    = state_reg;
    prdata_next   = prdata_reg;
    pready_next   = acc_go;
    pslverr_next  = 1'b0;
    // catch the stored enable once, the cycle after reset releases
    if (!loaded_reg) begin
      en_next = nv_enabled;
    end
    if (wr_go) begin
      if (paddr == `DHR_OFS_FEATURE) begin
        feature_next = pwdata[7:0];
      end else if (paddr == `DHR_OFS_CYL_LO) begin
        cyl_lo_next = pwdata[7:0];
      end else if (paddr == `DHR_OFS_CYL_HI) begin
        cyl_hi_next = pwdata[7:0];
      end else if (paddr == `DHR_OFS_THRESH) begin
        thresh_next = pwdata[15:0];
      end else if (paddr != `DHR_OFS_COMMAND) begin
        pslverr_next = 1'b1;  // status and data are read-only, the rest unmapped
      end
    end
    if (rd_go) begin
      prdata_next = 32'h0000_0000;
      if (paddr == `DHR_OFS_FEATURE) begin
        prdata_next[7:0] = feature_reg;
      end else if (paddr == `DHR_OFS_CYL_LO) begin
        prdata_next[7:0] = cyl_lo_reg;
      end else if (paddr == `DHR_OFS_CYL_HI) begin
        prdata_next[7:0] = cyl_hi_reg;
      end else if (paddr == `DHR_OFS_THRESH) begin
        prdata_next[15:0] = thresh_reg;
      end else if (paddr == `DHR_OFS_STATUS) begin
        prdata_next[`DHR_ST_DRQ]      = state_reg == dhr_pkg::DHR_XFER;
        prdata_next[`DHR_ST_ABORT]    = abort_reg;
        prdata_next[`DHR_ST_ENABLED]  = en_reg;
        prdata_next[`DHR_ST_EXCEEDED] = exceed_reg;
      end else if (paddr == `DHR_OFS_DATA) begin
        // reading with no sector pending returns zero and no error
        if (data_pop) begin
          prdata_next[7:0] = cur_byte;
          sum_next         = sum_reg + cur_byte;
          idx_next         = idx_reg + 9'd1;
          if (idx_reg == `DHR_LAST_BYTE) begin
            state_next = dhr_pkg::DHR_IDLE;  // exactly one sector
          end
        end
      end else if (paddr != `DHR_OFS_COMMAND) begin
        pslverr_next = 1'b1;
      end
    end
    // a new command drops any unfinished sector
    if (cmd_fire) begin
      abort_next = 1'b0;
      state_next = dhr_pkg::DHR_IDLE;
      idx_next   = 9'd0;
      sum_next   = 8'h00;
      // while disabled only the enable subcommand is accepted
      if (!en_reg && feature_reg != `DHR_FEA_ENABLE) begin
        abort_next = 1'b1;
      end else begin
        case (feature_reg)
          `DHR_FEA_READ, `DHR_FEA_THRESH: begin
            state_next    = dhr_pkg::DHR_XFER;
            thr_mode_next = feature_reg == `DHR_FEA_THRESH;
          end
          `DHR_FEA_AUTOSAVE: begin
            // data is always current, nothing to store
          end
          `DHR_FEA_ENABLE, `DHR_FEA_DISABLE: begin
            en_next  = feature_reg == `DHR_FEA_ENABLE;
            nvw_next = 1'b1;
          end
          `DHR_FEA_STATUS: begin
            exceed_next = exceeded;
            cyl_lo_next = exceeded ? `DHR_SIG_LO_BAD : `DHR_SIG_LO_OK;
            cyl_hi_next = exceeded ? `DHR_SIG_HI_BAD : `DHR_SIG_HI_OK;
          end
          default: begin
            abort_next = 1'b1;
          end
        endcase
      end
    end
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      feature_reg  <= 8'h00;
      cyl_lo_reg   <= 8'h00;
      cyl_hi_reg   <= 8'h00;
      thresh_reg   <= `DHR_THRESH_RESET;
      en_reg       <= 1'b0;
      loaded_reg   <= 1'b0;
      abort_reg    <= 1'b0;
      exceed_reg   <= 1'b0;
      thr_mode_reg <= 1'b0;
      idx_reg      <= 9'd0;
      sum_reg      <= 8'h00;
      nvw_reg      <= 1'b0;
      state_reg    <= dhr_pkg::DHR_IDLE;
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
    end else begin
      feature_reg  <= feature_next;
      cyl_lo_reg   <= cyl_lo_next;
      cyl_hi_reg   <= cyl_hi_next;
      thresh_reg   <= thresh_next;
      en_reg       <= en_next;
      loaded_reg   <= loaded_next;
      abort_reg    <= abort_next;
      exceed_reg   <= exceed_next;
      thr_mode_reg <= thr_mode_next;
      idx_reg      <= idx_next;
      sum_reg      <= sum_next;
      nvw_reg      <= nvw_next;
      state_reg    <= state_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign nv_write = nvw_reg;
  assign nv_value = en_reg;
  // ************************************************************
  // checks
  // ************************************************************
  property p_abort_unknown;
    cmd_fire && en_reg && !(feature_reg inside {`DHR_FEA_READ, `DHR_FEA_THRESH,
      `DHR_FEA_AUTOSAVE, `DHR_FEA_ENABLE, `DHR_FEA_DISABLE, `DHR_FEA_STATUS})
      |=> abort_reg && state_reg == dhr_pkg::DHR_IDLE;
  endproperty
  a_abort_unknown: assert property (p_abort_unknown) else $error("feature not aborted");
  property p_enable_store;
    cmd_fire && feature_reg == `DHR_FEA_ENABLE |=> en_reg && nv_write ##1 !nv_write;
  endproperty
  a_enable_store: assert property (p_enable_store) else $error("enable not stored");
  property p_disable_store;
    cmd_fire && en_reg && feature_reg == `DHR_FEA_DISABLE |=> !nv_value && nv_write;
  endproperty
  a_disable_store: assert property (p_disable_store) else $error("disable not stored");
  property p_autosave_noop;
    cmd_fire && en_reg && feature_reg == `DHR_FEA_AUTOSAVE
      |=> en_reg && !abort_reg && !nv_write && state_reg == dhr_pkg::DHR_IDLE;
  endproperty
  a_autosave_noop: assert property (p_autosave_noop) else $error("autosave had effect");
  property p_read_start;
    cmd_fire && en_reg && feature_reg inside {`DHR_FEA_READ, `DHR_FEA_THRESH}
      |=> state_reg == dhr_pkg::DHR_XFER && idx_reg == 9'd0 && sum_reg == 8'h00;
  endproperty
  a_read_start: assert property (p_read_start) else $error("sector not started");
  property p_version;
    data_pop && idx_reg == 9'd0 |=> prdata[7:0] == 8'h04 ##0 pready;
  endproperty
  a_version: assert property (p_version) else $error("bad structure version");
  property p_checksum;
    data_pop && idx_reg == `DHR_LAST_BYTE
      |=> 8'(prdata[7:0] + $past(sum_reg)) == 8'h00 && state_reg == dhr_pkg::DHR_IDLE;
  endproperty
  a_checksum: assert property (p_checksum) else $error("sector checksum wrong");
  property p_status_sig;
    cmd_fire && en_reg && feature_reg == `DHR_FEA_STATUS
      |=> (exceed_reg ? (cyl_lo_reg == `DHR_SIG_LO_BAD && cyl_hi_reg == `DHR_SIG_HI_BAD)
                      : (cyl_lo_reg == `DHR_SIG_LO_OK && cyl_hi_reg == `DHR_SIG_HI_OK))
          && exceed_reg == $past(exceeded);
  endproperty
  a_status_sig: assert property (p_status_sig) else $error("status signature wrong");
  property p_vendor_ver;
    data_pop && !thr_mode_reg && idx_reg == `DHR_OFS_VVER |=> prdata[7:0] == 8'h02;
  endproperty
  a_vendor_ver: assert property (p_vendor_ver) else $error("vendor version wrong");

endmodule // dhr_engine

// ===== dv/dhr_nv_model.sv
module dhr_nv_model (
  // clock
  input  wire logic clk_sys,
  // store port of the engine
  input  wire logic nv_write,
  input  wire logic nv_value,
  output logic      nv_enabled,
  output int        writes
);
  timeunit 1ns;
  timeprecision 1ps;
  // blank store at power-up
  initial begin
    nv_enabled = 1'b0;
    writes     = 0;
  end
  // no reset input: the bit must outlive every reset of the engine
  always @(posedge clk_sys) begin
    if (nv_write === 1'b1) begin
      nv_enabled <= nv_value;
      writes     <= writes + 1;
    end
  end
endmodule // dhr_nv_model

// ===== dv/test_drive_health_report_engine.sv
`include "dhr_cfg.svh"

module test_drive_health_report_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, last_err, nv_write, nv_value, nv_enabled, spare_borrowed = 1'b0;
  logic [31:0] spare_init = 32'h00C8_0064, spare_cur = 32'h00B4_0032;
  logic [7:0]  life_pct = 8'h5A;
  logic [63:0] erase_total = 64'h0000_0000_0001_2345, read_total = 64'h0000_0000_0000_0777;
  logic [31:0] ecc_all = 32'h1122_3344, ecc_cor = 32'h0000_0055, crc_errors = 32'h0000_0009;
  logic [31:0] commit_cnt = 32'h0000_0ABC, chip_erase_max = 32'h0001_869F;
  logic [7:0]  sec [512];
  logic [7:0]  ids [6] = '{`DHR_ID_SPARE, `DHR_ID_ERASE, `DHR_ID_ECC_ALL, `DHR_ID_ECC_COR,
                           `DHR_ID_READS, `DHR_ID_CRC};
  logic [7:0]  vals [6] = '{8'h32, 8'h5A, 8'h64, 8'h64, 8'h64, 8'h64};
  logic [15:0] thr [3] = '{16'h5A3C, 16'h5A32, 16'h5B32};
  int          error_cnt = 0, comparisons = 0, writes;

  dhr_engine #(.NCHIP(2)) uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spare_init(spare_init), .spare_cur(spare_cur), .life_pct(life_pct),
    .erase_total(erase_total), .ecc_all(ecc_all), .ecc_cor(ecc_cor), .read_total(read_total),
    .crc_errors(crc_errors), .commit_cnt(commit_cnt), .chip_erase_max(chip_erase_max),
    .spare_borrowed(spare_borrowed), .nv_enabled(nv_enabled), .nv_write(nv_write),
    .nv_value(nv_value));
  dhr_nv_model nv (.clk_sys(clk_sys), .nv_write(nv_write), .nv_value(nv_value),
    .nv_enabled(nv_enabled), .writes(writes));

  // 250 MHz
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // hold the request until pready is sampled high, then release for one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      final_report();
    end
    q = prdata; last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic cmd(input logic [7:0] f);
    apb(1'b1, `DHR_OFS_CYL_LO, {24'h00_0000, `DHR_SIG_LO_OK});
    apb(1'b1, `DHR_OFS_CYL_HI, {24'h00_0000, `DHR_SIG_HI_OK});
    apb(1'b1, `DHR_OFS_FEATURE, {24'h00_0000, f});
    apb(1'b1, `DHR_OFS_COMMAND, {24'h00_0000, `DHR_CMD_HEALTH});
    apb(1'b0, `DHR_OFS_STATUS, 32'h0000_0000);
  endtask

  function automatic logic [31:0] le32(input int b);
    return {sec[b+3], sec[b+2], sec[b+1], sec[b]};
  endfunction

  // pulls the pending sector and checks version, checksum and that drq drops
  task automatic read_sector();
    logic [7:0] sum = 8'h00;
    chk(q[`DHR_ST_DRQ], 1'b1);
    foreach (sec[i]) begin
      apb(1'b0, `DHR_OFS_DATA, 32'h0000_0000);
      sec[i] = q[7:0];
      sum += q[7:0];
    end
    chk(sum, 8'h00);
    chk({sec[1], sec[0]}, `DHR_STRUCT_VER);
    apb(1'b0, `DHR_OFS_STATUS, 32'h0000_0000);
    chk(q[`DHR_ST_DRQ], 1'b0);
  endtask

  task automatic check_data(input logic [7:0] wear, input logic [7:0] bb);
    cmd(`DHR_FEA_READ);
    read_sector();
    for (int k = 0; k < 6; k++) begin
      chk(sec[2+12*k], ids[k]);
      chk(sec[3+12*k], (k == 0) ? 8'h03 : 8'h02);
      chk(sec[5+12*k], vals[k]);
    end
    chk(le32(6), 32'h0032_0064);
    chk(le32(10), 32'h00E6_012C);
    chk(le32(18), erase_total[31:0]);
    chk(le32(30), ecc_all);
    chk(le32(42), ecc_cor);
    chk(le32(54), read_total[31:0]);
    chk(le32(66), crc_errors);
    chk({sec[362], sec[363], sec[367], sec[370]}, 32'h0000_0000);
    chk({sec[387], sec[386]}, `DHR_VENDOR_VER);
    chk(sec[396], wear);
    chk(sec[397], bb);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset();
    apb(1'b0, `DHR_OFS_THRESH, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(last_err, 1'b1);
    apb(1'b1, `DHR_OFS_STATUS, 32'h0000_00FF);
    chk(last_err, 1'b1);
    cmd(`DHR_FEA_READ); // blank store: commands other than enable abort
    chk(q[`DHR_ST_ABORT], 1'b1);
    $display("test registers done");
    cmd(`DHR_FEA_ENABLE);
    chk(writes, 1);
    chk(q[`DHR_ST_ENABLED], 1'b1);
    do_reset(); // enable state must come back from the store
    apb(1'b0, `DHR_OFS_STATUS, 32'h0000_0000);
    chk(q[`DHR_ST_ENABLED], 1'b1);
    cmd(8'hD3);
    chk(q[`DHR_ST_ABORT], 1'b1);
    cmd(`DHR_FEA_AUTOSAVE);
    chk(q, 32'h0000_0008);
    $display("test enable done");
    check_data(8'h00, 8'h00);
    chip_erase_max <= 32'h0001_86A0;
    spare_borrowed <= 1'b1;
    check_data(8'h01, 8'h01);
    $display("test read data done");
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, `DHR_OFS_THRESH, {16'h0000, thr[t]});
      cmd(`DHR_FEA_STATUS);
      chk(q[`DHR_ST_EXCEEDED], t != 1);
      apb(1'b0, `DHR_OFS_CYL_LO, 32'h0000_0000);
      chk(q[7:0], (t == 1) ? `DHR_SIG_LO_OK : `DHR_SIG_LO_BAD);
      apb(1'b0, `DHR_OFS_CYL_HI, 32'h0000_0000);
      chk(q[7:0], (t == 1) ? `DHR_SIG_HI_OK : `DHR_SIG_HI_BAD);
    end
    cmd(`DHR_FEA_THRESH);
    read_sector();
    chk({sec[2], sec[3], sec[14], sec[15]}, 32'hC432_E55B);
    chk({sec[26], sec[27], sec[28]}, 32'h00CB_0000);
    $display("test status and thresholds done");
    cmd(`DHR_FEA_DISABLE);
    chk(writes, 2);
    chk(q[`DHR_ST_ENABLED], 1'b0);
    cmd(`DHR_FEA_THRESH);
    chk(q[`DHR_ST_ABORT], 1'b1);
    $display("test disable done");
    final_report();
  end
endmodule // test_drive_health_report_engine
